//--- core/axis_cfg_map.svh
`ifndef AXIS_CFG_MAP_SVH
`define AXIS_CFG_MAP_SVH
// Summary of operation
// - Axis control applies only with mode bit 9
// - Axis status reports applied selection, bits 0-2
// - Axis control 16 bits, bits 3-15 reserved
// - Bit 0 selects motor or external encoder
// - Bit 1 selects hybrid control, both feedbacks
// - Bit 2 drops following distance when set
// - Limit control 16 bits, bits 3-15 reserved
// - Limit bit 0 inverts both switches
// - Limit bit 1 enables both switches
// - Trip gives class 1 error or class 2 warning
// - Clamping torque held as 16-bit value

`define ADDR_AXIS_CONTROL 5'h00
`define ADDR_AXIS_STATUS 5'h04
`define ADDR_CLAMP_TORQUE 5'h08
`define ADDR_LIMIT_CONTROL 5'h0c
`define ADDR_OP_MODE 5'h10
`define ADDR_IRQ_STATUS 5'h14
`define ADDR_IRQ_MASK 5'h18
`define ADDR_LIMIT_STATUS 5'h1c

`define AXIS_DEFINED_MASK 16'h0007
`define LIMIT_DEFINED_MASK 16'h0007
`define OP_MODE_DEFINED_MASK 16'h0200
`define IRQ_DEFINED_MASK 3'h7

`define AXIS_FEEDBACK_BIT 0
`define AXIS_HYBRID_BIT 1
`define AXIS_NO_FOLLOW_BIT 2
`define LIMIT_INVERT_BIT 0
`define LIMIT_ENABLE_BIT 1
`define LIMIT_WARN_BIT 2
`define OP_MODE_AXIS_BIT 9
`define IRQ_ERROR_BIT 0
`define IRQ_WARNING_BIT 1
`define IRQ_AXIS_CHANGE_BIT 2

`define AXIS_CONTROL_RESET 16'h0000
`define LIMIT_CONTROL_RESET 16'h0000
`define CLAMP_TORQUE_RESET 16'h0000
`define OP_MODE_RESET 16'h0000
`define IRQ_MASK_RESET 3'h0

`define RESP_OKAY 2'h0
`define RESP_DECODEERROR 2'h3
`endif

//--- core/axis_cfg_pkg.sv
package axis_cfg_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic no_follow;
        logic hybrid;
        logic feedback_ext;
    } axis_sel_t;
endpackage

//--- core/limit_if.sv
interface limit_if #(
    parameter int N_SWITCH = 2
);
    logic invert;
    logic enable;
    logic warn_sel;
    logic [N_SWITCH-1:0] level;
    logic [N_SWITCH-1:0] tripped;
    logic err;
    logic warn;

    modport cfg (
        output invert, enable, warn_sel,
        input level, tripped, err, warn
    );

    modport mon (
        input invert, enable, warn_sel,
        output level, tripped, err, warn
    );
endinterface

//--- core/limit_switch_monitor.sv
module limit_switch_monitor #(
    parameter int N_SWITCH = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [N_SWITCH-1:0] switch_pin,
    limit_if.mon lim
);
    logic [N_SWITCH-1:0] meta_r;
    logic [N_SWITCH-1:0] sync_r;
    logic [N_SWITCH-1:0] level_r;
    logic [N_SWITCH-1:0] tripped_r;
    logic err_r;
    logic warn_r;

    genvar i;
    generate
        for (i = 0; i < N_SWITCH; i++) begin : g_sync
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= switch_pin[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    wire [N_SWITCH-1:0] level_nxt = sync_r ^ {N_SWITCH{lim.invert}};
    wire [N_SWITCH-1:0] tripped_nxt = lim.enable ? level_nxt : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level_r <= '0;
            tripped_r <= '0;
            err_r <= 1'b0;
            warn_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
            tripped_r <= tripped_nxt;
            err_r <= |tripped_nxt && !lim.warn_sel;
            warn_r <= |tripped_nxt && lim.warn_sel;
        end
    end

    assign lim.level = level_r;
    assign lim.tripped = tripped_r;
    assign lim.err = err_r;
    assign lim.warn = warn_r;
endmodule

//--- core/axis_feedback_and_limit_switch_cfg.sv
`include "axis_cfg_map.svh"

module axis_feedback_and_limit_switch_cfg
    import axis_cfg_pkg::*;
#(
    parameter int N_SWITCH = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic limit_pos_pin,
    input wire logic limit_neg_pin,
    output logic feedback_external,
    output logic hybrid_feedback,
    output logic no_following_distance,
    output logic axis_status_valid,
    output logic [15:0] clamping_torque_out,
    output logic class1_diag_error,
    output logic class2_diag_warning,
    output logic irq
);

    // Merges the low half of a bus write into a 16-bit register by byte lane.
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    // Picks out the three defined axis selection bits of a control word.
    function automatic axis_sel_t axis_bits(
        input logic [15:0] word
    );
        axis_sel_t s;
        s.feedback_ext = word[`AXIS_FEEDBACK_BIT];
        s.hybrid = word[`AXIS_HYBRID_BIT];
        s.no_follow = word[`AXIS_NO_FOLLOW_BIT];
        return s;
    endfunction

    limit_if #(.N_SWITCH(N_SWITCH)) lim ();

    bus_state_t state_r;
    bus_state_t state_nxt;
    logic waitrequest_r;
    logic [31:0] readdata_r;
    logic [1:0] response_r;
    logic [15:0] axis_control_r;
    logic [15:0] limit_control_r;
    logic [15:0] clamp_torque_r;
    logic [15:0] op_mode_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_status_nxt;
    logic [2:0] irq_mask_r;
    logic irq_r;
    axis_sel_t applied_r;
    axis_sel_t applied_nxt;
    logic status_valid_r;
    logic err_seen_r;
    logic warn_seen_r;
    logic class1_r;
    logic class2_r;

    // Address decode.
    wire aligned = (avs_address[1:0] == 2'b00);
    wire hit_axis_ctrl = aligned && (avs_address == `ADDR_AXIS_CONTROL);
    wire hit_axis_stat = aligned && (avs_address == `ADDR_AXIS_STATUS);
    wire hit_torque = aligned && (avs_address == `ADDR_CLAMP_TORQUE);
    wire hit_limit_ctrl = aligned && (avs_address == `ADDR_LIMIT_CONTROL);
    wire hit_op_mode = aligned && (avs_address == `ADDR_OP_MODE);
    wire hit_irq_stat = aligned && (avs_address == `ADDR_IRQ_STATUS);
    wire hit_irq_mask = aligned && (avs_address == `ADDR_IRQ_MASK);
    wire hit_limit_stat = aligned && (avs_address == `ADDR_LIMIT_STATUS);
    wire mapped = hit_axis_ctrl || hit_axis_stat || hit_torque || hit_limit_ctrl
        || hit_op_mode || hit_irq_stat || hit_irq_mask || hit_limit_stat;

    // A request is answered in the cycle after it is seen, and a write takes
    // effect only at the edge where the master sees waitrequest low.
    wire request = avs_read || avs_write;
    wire completing = (state_r == BUS_ACK);
    wire wr_commit = completing && avs_write;

    always_comb begin
        case (state_r)
            BUS_IDLE: begin
                state_nxt = request ? BUS_ACK : BUS_IDLE;
            end
            BUS_ACK: begin
                state_nxt = BUS_IDLE;
            end
            default: begin
                state_nxt = BUS_IDLE;
            end
        endcase
    end

    // Operation mode bit 9 gates the whole axis selection.
    wire axis_mode_on = op_mode_r[`OP_MODE_AXIS_BIT];
    assign applied_nxt = axis_mode_on ? axis_bits(axis_control_r) : axis_sel_t'(3'b000);

    // The status word shows what is really applied, not what was written.
    wire [15:0] axis_status_word = {13'h0000, applied_r.no_follow, applied_r.hybrid,
        applied_r.feedback_ext};

    wire [15:0] limit_status_word = {12'h000, lim.tripped, lim.level};

    // Read mux; reserved bits come back as zero.
    wire [31:0] rd_mux =
        hit_axis_ctrl ? {16'h0000, axis_control_r} :
        hit_axis_stat ? {16'h0000, axis_status_word} :
        hit_torque ? {16'h0000, clamp_torque_r} :
        hit_limit_ctrl ? {16'h0000, limit_control_r} :
        hit_op_mode ? {16'h0000, op_mode_r} :
        hit_irq_stat ? {29'h00000000, irq_status_r} :
        hit_irq_mask ? {29'h00000000, irq_mask_r} :
        hit_limit_stat ? {16'h0000, limit_status_word} :
        32'h00000000;

    // Events are edges of the error, warning and applied selection.
    wire err_event = lim.err && !err_seen_r;
    wire warn_event = lim.warn && !warn_seen_r;
    wire axis_event = (applied_nxt != applied_r);
    wire [2:0] irq_set = {axis_event, warn_event, err_event};
    wire [2:0] irq_clr = (wr_commit && hit_irq_stat && avs_byteenable[0]) ?
        avs_writedata[2:0] : 3'h0;

    // A new event in the clearing cycle survives the clear.
    assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

    wire irq_nxt = |(irq_status_nxt & irq_mask_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= BUS_IDLE;
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h00000000;
            response_r <= `RESP_OKAY;
        end else begin
            state_r <= state_nxt;
            waitrequest_r <= !(state_nxt == BUS_ACK);
            if (state_r == BUS_IDLE && request) begin
                readdata_r <= avs_read ? rd_mux : 32'h00000000;
                response_r <= mapped ? `RESP_OKAY : `RESP_DECODEERROR;
            end
        end
    end

    // Only the defined bits are kept, so reserved bits never store.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            axis_control_r <= `AXIS_CONTROL_RESET;
        end else if (wr_commit && hit_axis_ctrl) begin
            axis_control_r <= merge16(axis_control_r, avs_writedata, avs_byteenable)
                & `AXIS_DEFINED_MASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            limit_control_r <= `LIMIT_CONTROL_RESET;
        end else if (wr_commit && hit_limit_ctrl) begin
            limit_control_r <= merge16(limit_control_r, avs_writedata, avs_byteenable)
                & `LIMIT_DEFINED_MASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clamp_torque_r <= `CLAMP_TORQUE_RESET;
        end else if (wr_commit && hit_torque) begin
            clamp_torque_r <= merge16(clamp_torque_r, avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            op_mode_r <= `OP_MODE_RESET;
        end else if (wr_commit && hit_op_mode) begin
            op_mode_r <= merge16(op_mode_r, avs_writedata, avs_byteenable)
                & `OP_MODE_DEFINED_MASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_mask_r <= `IRQ_MASK_RESET;
        end else if (wr_commit && hit_irq_mask && avs_byteenable[0]) begin
            irq_mask_r <= avs_writedata[2:0] & `IRQ_DEFINED_MASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_status_r <= 3'h0;
            irq_r <= 1'b0;
            err_seen_r <= 1'b0;
            warn_seen_r <= 1'b0;
        end else begin
            irq_status_r <= irq_status_nxt;
            irq_r <= irq_nxt;
            err_seen_r <= lim.err;
            warn_seen_r <= lim.warn;
        end
    end

    // Applied selection and status follow the control word one cycle later.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            applied_r <= axis_sel_t'(3'b000);
            status_valid_r <= 1'b0;
        end else begin
            applied_r <= applied_nxt;
            status_valid_r <= axis_mode_on;
        end
    end

    // Diagnostics are levels that stand while a switch stays tripped.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            class1_r <= 1'b0;
            class2_r <= 1'b0;
        end else begin
            class1_r <= lim.err;
            class2_r <= lim.warn;
        end
    end

    assign lim.invert = limit_control_r[`LIMIT_INVERT_BIT];
    assign lim.enable = limit_control_r[`LIMIT_ENABLE_BIT];
    assign lim.warn_sel = limit_control_r[`LIMIT_WARN_BIT];

    limit_switch_monitor #(
        .N_SWITCH(N_SWITCH)
    ) u_monitor (
        .clock(clock),
        .rst(rst),
        .switch_pin(N_SWITCH'({limit_neg_pin, limit_pos_pin})),
        .lim(lim.mon)
    );

    assign avs_readdata = readdata_r;
    assign avs_waitrequest = waitrequest_r;
    assign avs_response = response_r;
    assign feedback_external = applied_r.feedback_ext;
    assign hybrid_feedback = applied_r.hybrid;
    assign no_following_distance = applied_r.no_follow;
    assign axis_status_valid = status_valid_r;
    assign clamping_torque_out = clamp_torque_r;
    assign class1_diag_error = class1_r;
    assign class2_diag_warning = class2_r;
    assign irq = irq_r;
endmodule

//--- sim/axis_cfg_asserts.sv
`include "axis_cfg_map.svh"

module axis_cfg_asserts #(
    parameter int N_SWITCH = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic limit_pos_pin,
    input wire logic limit_neg_pin,
    input wire logic feedback_external,
    input wire logic hybrid_feedback,
    input wire logic no_following_distance,
    input wire logic axis_status_valid,
    input wire logic [15:0] clamping_torque_out,
    input wire logic class1_diag_error,
    input wire logic class2_diag_warning,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire wr_ack = avs_write && !avs_waitrequest;
    wire rd_ack = avs_read && !avs_waitrequest;
    wire [2:0] sel = {no_following_distance, hybrid_feedback, feedback_external};

    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_request_answered: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_idle_wait_high: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_response_code: assert property (!avs_waitrequest |-> avs_response == 2'h0 || avs_response == 2'h3)
        else $error("undefined response code");
    a_control_reserved: assert property (rd_ack && avs_address == `ADDR_AXIS_CONTROL |-> avs_readdata[31:3] == '0)
        else $error("axis control reserved bits read nonzero");
    a_status_match: assert property (rd_ack && avs_address == `ADDR_AXIS_STATUS |-> avs_readdata == {29'h0, sel})
        else $error("axis status differs from applied selection");
    a_axis_gate: assert property (!axis_status_valid |-> sel == 3'h0)
        else $error("axis settings applied while inactive");
    a_diag_exclusive: assert property (!(class1_diag_error && class2_diag_warning))
        else $error("error and warning raised together");
    a_torque_cause: assert property ($changed(clamping_torque_out) |-> $past(wr_ack) || $past(wr_ack, 2))
        else $error("clamping torque changed without a write");

    c_axis_write: cover property (wr_ack && avs_address == `ADDR_AXIS_CONTROL);
    c_error: cover property ($rose(class1_diag_error));
    c_warning: cover property ($rose(class2_diag_warning));
    c_irq: cover property ($rose(irq));
endmodule

//--- sim/mcu_model.sv
module mcu_model (
    input wire logic clock,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0] avs_response,
    output logic [4:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end

    // Only the low word is meaningful; the idle data is inverted so a stale value never looks valid.
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [31:0] q, output logic [1:0] r);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= 4'h3;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~avs_writedata;
    endtask
endmodule

//--- sim/axis_feedback_and_limit_switch_cfg_tb.sv
`include "axis_cfg_map.svh"

module axis_feedback_and_limit_switch_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [4:0] a; logic [15:0] d; logic [31:0] e; logic [1:0] r;} row_t;
    logic clock, rst, pos_pin, neg_pin, rd_req, wr_req, waitreq, fb, hyb, nfd, valid, c1, c2, irq;
    logic [4:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic [1:0] resp;
    logic [15:0] torque;
    int fail_count = 0;
    int tests_run = 0;
    row_t rows[7] = '{
        '{`ADDR_AXIS_CONTROL, 16'hfffd, 32'h5, 2'h0},
        '{`ADDR_CLAMP_TORQUE, 16'hbeef, 32'hbeef, 2'h0},
        '{`ADDR_LIMIT_CONTROL, 16'hfff8, 32'h0, 2'h0},
        '{`ADDR_LIMIT_CONTROL, 16'h0005, 32'h5, 2'h0},
        '{`ADDR_AXIS_STATUS, 16'h0007, 32'h0, 2'h0},
        '{5'h02, 16'h1234, 32'h0, 2'h3},
        '{`ADDR_IRQ_MASK, 16'hffff, 32'h7, 2'h0}};

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    axis_feedback_and_limit_switch_cfg axis_feedback_and_limit_switch_cfg_i (.clock(clock), .rst(rst),
        .avs_address(addr), .avs_read(rd_req), .avs_write(wr_req), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitreq), .avs_response(resp), .limit_pos_pin(pos_pin),
        .limit_neg_pin(neg_pin), .feedback_external(fb), .hybrid_feedback(hyb), .no_following_distance(nfd),
        .axis_status_valid(valid), .clamping_torque_out(torque), .class1_diag_error(c1),
        .class2_diag_warning(c2), .irq(irq));
    mcu_model mcu_model_i (.clock(clock), .avs_waitrequest(waitreq), .avs_readdata(rdata),
        .avs_response(resp), .avs_address(addr), .avs_read(rd_req), .avs_write(wr_req),
        .avs_writedata(wdata), .avs_byteenable(be));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        logic [1:0] r;
        mcu_model_i.xfer(1'b1, a, d, q, r);
    endtask

    task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        mcu_model_i.xfer(1'b0, a, 16'h0, q, r);
        check(name, q, e);
        check({name, "_resp"}, {30'h0, r}, {30'h0, er});
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        pos_pin = 1'b0;
        neg_pin = 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("wait_reset", {31'h0, waitreq}, 32'h1);
        rd_chk("ctrl_reset", `ADDR_AXIS_CONTROL, 32'h0, 2'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd_chk("row", rows[i].a, rows[i].e, rows[i].r);
        end
        check("torque_out", {16'h0, torque}, 32'hbeef);
        check("axis_inactive", {29'h0, nfd, hyb, fb}, 32'h0);
        wr(`ADDR_OP_MODE, 16'h0200);
        for (int v = 0; v < 8; v++) begin
            wr(`ADDR_AXIS_CONTROL, 16'(v));
            wait_n(2);
            check("axis_out", {28'h0, valid, nfd, hyb, fb}, 32'(v + 8));
            rd_chk("axis_status", `ADDR_AXIS_STATUS, 32'(v), 2'h0);
        end
        wr(`ADDR_OP_MODE, 16'h0000);
        wait_n(2);
        check("axis_off", {28'h0, valid, nfd, hyb, fb}, 32'h0);
        rd_chk("status_off", `ADDR_AXIS_STATUS, 32'h0, 2'h0);
        wr(`ADDR_IRQ_MASK, 16'h0003);
        wr(`ADDR_IRQ_STATUS, 16'h0007);
        wr(`ADDR_LIMIT_CONTROL, 16'h0002);
        pos_pin <= 1'b1;
        wait_n(6);
        check("trip_error", {30'h0, c2, c1}, 32'h1);
        check("irq_error", {31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_STATUS, 16'h0001);
        wait_n(2);
        check("irq_clear", {31'h0, irq}, 32'h0);
        wr(`ADDR_LIMIT_CONTROL, 16'h0006);
        wait_n(3);
        check("trip_warn", {30'h0, c2, c1}, 32'h2);
        check("irq_warn", {31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_MASK, 16'h0000);
        wait_n(2);
        check("irq_masked", {31'h0, irq}, 32'h0);
        rd_chk("irq_status", `ADDR_IRQ_STATUS, 32'h2, 2'h0);
        pos_pin <= 1'b0;
        wr(`ADDR_LIMIT_CONTROL, 16'h0003);
        wait_n(6);
        check("trip_invert", {30'h0, c2, c1}, 32'h1);
        rd_chk("limit_invert", `ADDR_LIMIT_STATUS, 32'hf, 2'h0);
        wr(`ADDR_LIMIT_CONTROL, 16'h0001);
        wait_n(3);
        check("trip_disabled", {30'h0, c2, c1}, 32'h0);
        // The negative switch alone must trip as well, since enable covers both.
        neg_pin <= 1'b1;
        wr(`ADDR_LIMIT_CONTROL, 16'h0002);
        wait_n(6);
        check("trip_neg", {30'h0, c2, c1}, 32'h1);
        rd_chk("limit_neg", `ADDR_LIMIT_STATUS, 32'ha, 2'h0);
        rst <= 1'b1;
        wait_n(2);
        rst <= 1'b0;
        @(posedge clock);
        check("torque_rst", {16'h0, torque}, 32'h0);
        check("diag_rst", {29'h0, irq, c2, c1}, 32'h0);
        rd_chk("limit_rst", `ADDR_LIMIT_CONTROL, 32'h0, 2'h0);
        final_report();
    end
endmodule

bind axis_feedback_and_limit_switch_cfg axis_cfg_asserts #(.N_SWITCH(N_SWITCH)) axis_cfg_asserts_i (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .limit_pos_pin(limit_pos_pin),
    .limit_neg_pin(limit_neg_pin), .feedback_external(feedback_external), .hybrid_feedback(hybrid_feedback),
    .no_following_distance(no_following_distance), .axis_status_valid(axis_status_valid),
    .clamping_torque_out(clamping_torque_out), .class1_diag_error(class1_diag_error),
    .class2_diag_warning(class2_diag_warning), .irq(irq));
